// ---- src/smw_consts.svh ----
// constants for the static memory wait-state sequencer
`ifndef SMW_CONSTS_SVH
`define SMW_CONSTS_SVH
`define SMW_EXNW_DISABLED 2'h0
`define SMW_EXNW_FROZEN 2'h2
`define SMW_EXNW_READY 2'h3
`define SMW_TDF_W 4
`define SMW_TDF_MAX 4'hF
`define SMW_CNT_W 9
`define SMW_CNT_ONE 9'h001
`define SMW_CNT_ZERO 9'h000
`define SMW_TDF_ZERO 4'h0
`define SMW_TDF_ONE 4'h1
`define SMW_CS_NONE_BIT 1'h0
`endif

// ---- src/smw_pkg.sv ----
// types for the static memory wait-state sequencer
package smw_pkg;
    typedef enum logic [2:0] {
        SMW_IDLE = 3'h0,
        SMW_CSWAIT = 3'h1,
        SMW_RELOAD = 3'h2,
        SMW_R2W = 3'h3,
        SMW_TDF = 3'h4,
        SMW_SETUP = 3'h5,
        SMW_PULSE = 3'h6,
        SMW_HOLD = 3'h7
    } smw_state_t;
endpackage

// ---- src/smw_cfg_mem.sv ----
// per-chip-select mode word storage with registered read port
`timescale 1ns/1ps
`default_nettype none
module smw_cfg_mem #(
    parameter int CHIP_SELECT_N = 8,
    parameter int AW = 3,
    parameter int DW = 8
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // write port
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [DW-1:0] wr_data,
    // read port
    input wire logic [AW-1:0] rd_addr,
    output logic [DW-1:0] rd_data
);
    logic [DW-1:0] mem_r [CHIP_SELECT_N];
    logic [DW-1:0] rd_data_r;

    // storage; reset value is mode zero, float count zero
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < CHIP_SELECT_N; i++) begin
                mem_r[i] <= '0;
            end
            rd_data_r <= '0;
        end else begin
            if (wr_en) begin
                mem_r[wr_addr] <= wr_data;
            end
            rd_data_r <= mem_r[rd_addr];
        end
    end
    assign rd_data = rd_data_r;
endmodule // smw_cfg_mem
`default_nettype wire

// ---- src/smw_ctrl.sv ----
// wait-state sequencer of an asynchronous static memory controller
`timescale 1ns/1ps
`default_nettype none
`include "smw_consts.svh"
module smw_ctrl #(
    parameter int CHIP_SELECT_N = 8,
    parameter int CSW = 3
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // configuration writes; mode word = {tdf_mode, read_mode, ext_wait_mode, tdf}
    input wire logic cs_mode_reg_wr,
    input wire logic [CSW-1:0] cfg_cs,
    input wire logic [`SMW_TDF_W+3:0] cfg_mode_data,
    input wire logic timing_reg_wr,
    input wire logic slow_clock_mode,
    // access request
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_internal,
    input wire logic req_write,
    input wire logic [CSW-1:0] req_cs,
    input wire logic [`SMW_CNT_W-1:0] req_setup,
    input wire logic [`SMW_CNT_W-1:0] req_pulse,
    input wire logic [`SMW_CNT_W-1:0] req_hold,
    // pins
    input wire logic ext_wait_n,
    output logic [CHIP_SELECT_N-1:0] chip_select_n,
    output logic read_strobe_n,
    output logic write_strobe_n,
    // status
    output logic busy,
    output logic reload_pending,
    output logic [`SMW_TDF_W-1:0] float_left
);
    localparam int MW = `SMW_TDF_W + 4;

    smw_pkg::smw_state_t st_r, st_nxt;
    logic [`SMW_CNT_W-1:0] cnt_r, cnt_nxt;
    logic [`SMW_TDF_W-1:0] tdf_r, tdf_nxt;
    logic reload_r, reload_nxt;
    logic slow_r, slow_nxt;
    logic prev_valid_r, prev_valid_nxt;
    logic prev_read_r, prev_read_nxt;
    logic [CSW-1:0] prev_cs_r, prev_cs_nxt;
    logic [CSW-1:0] cur_cs_r, cur_cs_nxt;
    logic cur_wr_r, cur_wr_nxt;
    logic [MW-1:0] act_mode_r, act_mode_nxt;
    logic [`SMW_CNT_W-1:0] hold_r, hold_nxt;
    logic [`SMW_CNT_W-1:0] pulse_r, pulse_nxt;
    logic [CHIP_SELECT_N-1:0] cs_n_r, cs_n_nxt;
    logic rd_n_r, rd_n_nxt;
    logic wr_n_r, wr_n_nxt;
    logic ready_wait_r, ready_wait_nxt;
    logic sync1_r, sync2_r;
    logic [MW-1:0] mem_rd;

    // per-chip-select mode words, read for the chip select being requested
    smw_cfg_mem #(.CHIP_SELECT_N(CHIP_SELECT_N), .AW(CSW), .DW(MW)) u_mem (
        .mclk(mclk),
        .rst_n(rst_n),
        .wr_en(cs_mode_reg_wr),
        .wr_addr(cfg_cs),
        .wr_data(cfg_mode_data),
        .rd_addr(req_cs),
        .rd_data(mem_rd)
    );

    ////////////////////////////////////////////////////////////////////
    // wait input synchroniser; first stage feeds only the second
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_r <= 1'b1;
            sync2_r <= 1'b1;
        end else begin
            sync1_r <= ext_wait_n;
            sync2_r <= sync1_r;
        end
    end

    // mode word fields of the active access
    logic act_tdf_mode, act_read_mode;
    logic [1:0] act_wait_mode;
    logic [`SMW_TDF_W-1:0] act_tdf;
    logic wait_low;
    assign act_tdf_mode = act_mode_r[MW-1];
    assign act_read_mode = act_mode_r[MW-2];
    assign act_wait_mode = act_mode_r[MW-3:MW-4];
    assign act_tdf = act_mode_r[`SMW_TDF_W-1:0];
    assign wait_low = !sync2_r;

    ////////////////////////////////////////////////////////////////////
    // sequencer next state
    logic need_cs, need_r2w, need_tdf, fits_tdf;
    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        tdf_nxt = tdf_r;
        reload_nxt = reload_r;
        slow_nxt = slow_r;
        prev_valid_nxt = prev_valid_r;
        prev_read_nxt = prev_read_r;
        prev_cs_nxt = prev_cs_r;
        cur_cs_nxt = cur_cs_r;
        cur_wr_nxt = cur_wr_r;
        act_mode_nxt = act_mode_r;
        hold_nxt = hold_r;
        pulse_nxt = pulse_r;
        cs_n_nxt = cs_n_r;
        rd_n_nxt = rd_n_r;
        wr_n_nxt = wr_n_r;
        ready_wait_nxt = ready_wait_r;
        req_ready = 1'b0;
        need_cs = prev_valid_r && (req_cs != prev_cs_r);
        need_r2w = prev_valid_r && prev_read_r && req_write;
        // float applies to other-device read or any write after a read
        need_tdf = prev_valid_r && prev_read_r && (tdf_r != `SMW_TDF_ZERO)
            && (req_write || (req_cs != prev_cs_r));
        // optimization: the next setup can absorb what is left of the float
        fits_tdf = act_tdf_mode
            && ({{(`SMW_CNT_W-`SMW_TDF_W){1'b0}}, tdf_r} <= req_setup);
        // a mode write arms reload; set wins over the consume below
        if (cs_mode_reg_wr) begin
            reload_nxt = 1'b1;
        end
        // the float counter runs down in every state but setup, even while internal accesses go by
        if (tdf_r != `SMW_TDF_ZERO && st_r != smw_pkg::SMW_SETUP) begin
            tdf_nxt = tdf_r - `SMW_TDF_ONE;
        end
        case (st_r)
            smw_pkg::SMW_IDLE: begin
                if (slow_clock_mode != slow_r) begin
                    slow_nxt = slow_clock_mode;
                    reload_nxt = 1'b1;
                end
                if (req_valid && req_internal) begin
                    req_ready = 1'b1;
                end else if (req_valid && (!need_tdf || fits_tdf)) begin
                    // taking the access at once avoids a wasted cycle for the clear
                    if (need_tdf) begin
                        tdf_nxt = `SMW_TDF_ZERO;
                    end
                    act_mode_nxt = mem_rd;
                    cur_cs_nxt = req_cs;
                    cur_wr_nxt = req_write;
                    pulse_nxt = req_pulse;
                    hold_nxt = req_hold;
                    cnt_nxt = req_setup;
                    if (need_cs) begin
                        st_nxt = smw_pkg::SMW_CSWAIT;
                        reload_nxt = cs_mode_reg_wr;
                    end else if (reload_r) begin
                        st_nxt = smw_pkg::SMW_RELOAD;
                    end else if (need_r2w) begin
                        st_nxt = smw_pkg::SMW_R2W;
                    end else begin
                        st_nxt = smw_pkg::SMW_SETUP;
                    end
                end
            end
            smw_pkg::SMW_CSWAIT: begin
                st_nxt = need_r2w ? smw_pkg::SMW_R2W : smw_pkg::SMW_SETUP;
            end
            smw_pkg::SMW_RELOAD: begin
                reload_nxt = cs_mode_reg_wr;
                act_mode_nxt = mem_rd;
                st_nxt = need_r2w ? smw_pkg::SMW_R2W : smw_pkg::SMW_SETUP;
            end
            smw_pkg::SMW_R2W: begin
                st_nxt = smw_pkg::SMW_SETUP;
            end
            smw_pkg::SMW_SETUP: begin
                cs_n_nxt = ~({{(CHIP_SELECT_N-1){1'b0}}, 1'b1} << cur_cs_r);
                if (cnt_r <= `SMW_CNT_ONE) begin
                    st_nxt = smw_pkg::SMW_PULSE;
                    cnt_nxt = pulse_r;
                    rd_n_nxt = cur_wr_r;
                    wr_n_nxt = !cur_wr_r;
                end else begin
                    cnt_nxt = cnt_r - `SMW_CNT_ONE;
                end
            end
            smw_pkg::SMW_PULSE: begin
                if (act_wait_mode == `SMW_EXNW_FROZEN && wait_low) begin
                    cnt_nxt = cnt_r;
                end else if (cnt_r <= `SMW_CNT_ONE) begin
                    if (act_wait_mode == `SMW_EXNW_READY && (wait_low || ready_wait_r)
                        && !(ready_wait_r && !wait_low)) begin
                        ready_wait_nxt = 1'b1;
                    end else begin
                        ready_wait_nxt = 1'b0;
                        st_nxt = smw_pkg::SMW_HOLD;
                        cnt_nxt = hold_r;
                        rd_n_nxt = 1'b1;
                        wr_n_nxt = 1'b1;
                        // float period starts at the controlling strobe rising
                        if (!cur_wr_r && act_read_mode) begin
                            tdf_nxt = act_tdf;
                        end
                    end
                end else begin
                    cnt_nxt = cnt_r - `SMW_CNT_ONE;
                end
            end
            smw_pkg::SMW_HOLD: begin
                if (cnt_r <= `SMW_CNT_ONE) begin
                    cs_n_nxt = '1;
                    st_nxt = smw_pkg::SMW_IDLE;
                    prev_valid_nxt = 1'b1;
                    prev_read_nxt = !cur_wr_r;
                    prev_cs_nxt = cur_cs_r;
                    req_ready = 1'b1;
                    if (!cur_wr_r && !act_read_mode) begin
                        tdf_nxt = act_tdf;
                    end else if (!cur_wr_r && tdf_r != `SMW_TDF_ZERO) begin
                        tdf_nxt = tdf_r - `SMW_TDF_ONE;
                    end
                    // hold cycles already spent count, so only what is left is waited
                    if (!cur_wr_r && !act_tdf_mode && tdf_nxt != `SMW_TDF_ZERO) begin
                        st_nxt = smw_pkg::SMW_TDF;
                    end
                end else begin
                    cnt_nxt = cnt_r - `SMW_CNT_ONE;
                end
            end
            smw_pkg::SMW_TDF: begin
                // internal accesses never wait for the external bus to float
                if (req_valid && req_internal) begin
                    req_ready = 1'b1;
                end
                if (tdf_r <= `SMW_TDF_ONE) begin
                    st_nxt = smw_pkg::SMW_IDLE;
                end
            end
            default: begin
                st_nxt = smw_pkg::SMW_IDLE;
            end
        endcase
    end

    // sequencer registers
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= smw_pkg::SMW_IDLE;
            cnt_r <= `SMW_CNT_ZERO;
            tdf_r <= `SMW_TDF_ZERO;
            reload_r <= 1'b0;
            slow_r <= 1'b0;
            prev_valid_r <= 1'b0;
            prev_read_r <= 1'b0;
            prev_cs_r <= '0;
            cur_cs_r <= '0;
            cur_wr_r <= 1'b0;
            act_mode_r <= '0;
            hold_r <= `SMW_CNT_ZERO;
            pulse_r <= `SMW_CNT_ZERO;
            cs_n_r <= '1;
            rd_n_r <= 1'b1;
            wr_n_r <= 1'b1;
            ready_wait_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            tdf_r <= tdf_nxt;
            reload_r <= reload_nxt;
            slow_r <= slow_nxt;
            prev_valid_r <= prev_valid_nxt;
            prev_read_r <= prev_read_nxt;
            prev_cs_r <= prev_cs_nxt;
            cur_cs_r <= cur_cs_nxt;
            cur_wr_r <= cur_wr_nxt;
            act_mode_r <= act_mode_nxt;
            hold_r <= hold_nxt;
            pulse_r <= pulse_nxt;
            cs_n_r <= cs_n_nxt;
            rd_n_r <= rd_n_nxt;
            wr_n_r <= wr_n_nxt;
            ready_wait_r <= ready_wait_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs; timing register writes alone never arm a reload
    assign chip_select_n = cs_n_r;
    assign read_strobe_n = rd_n_r;
    assign write_strobe_n = wr_n_r;
    assign busy = (st_r != smw_pkg::SMW_IDLE);
    assign reload_pending = reload_r;
    assign float_left = tdf_r;
endmodule // smw_ctrl
`default_nettype wire

// ---- testbench/smw_ctrl_assertions.sv ----
// port-level checker for the wait-state sequencer
`timescale 1ns/1ps
`default_nettype none
`include "smw_consts.svh"
module smw_ctrl_assertions #(
    parameter int CHIP_SELECT_N = 8,
    parameter int CSW = 3
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // configuration and request
    input wire logic cs_mode_reg_wr,
    input wire logic timing_reg_wr,
    input wire logic slow_clock_mode,
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic req_internal,
    // pins and status
    input wire logic [CHIP_SELECT_N-1:0] chip_select_n,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic busy,
    input wire logic reload_pending,
    input wire logic [`SMW_TDF_W-1:0] float_left
);
default clocking cb @(posedge mclk); endclocking
default disable iff (!rst_n);
////////////////////////////////////////////////////////////////////////////////
// select and strobe shape
property p_one_cs; $onehot0(~chip_select_n); endproperty
a_one_cs: assert property (p_one_cs) else $error("two selects low");
property p_strobe_cs; !(read_strobe_n && write_strobe_n) |-> !(&chip_select_n); endproperty
a_strobe_cs: assert property (p_strobe_cs) else $error("strobe without select");
property p_one_strobe; !(!read_strobe_n && !write_strobe_n); endproperty
a_one_strobe: assert property (p_one_strobe) else $error("both strobes low");
// a switch between two devices must pass through an all-high cycle
property p_cs_gap; !(&$past(chip_select_n)) && !(&chip_select_n) |-> $stable(chip_select_n);
endproperty
a_cs_gap: assert property (p_cs_gap) else $error("no idle cycle between selects");
property p_idle_high; !busy |-> (&chip_select_n) && read_strobe_n && write_strobe_n; endproperty
a_idle_high: assert property (p_idle_high) else $error("lines low while idle");
////////////////////////////////////////////////////////////////////////////////
// reload, internal path and float count
property p_int_fast; req_valid && req_internal && !busy |-> req_ready; endproperty
a_int_fast: assert property (p_int_fast) else $error("internal access delayed");
property p_reload_set; cs_mode_reg_wr |=> reload_pending; endproperty
a_reload_set: assert property (p_reload_set) else $error("mode write lost");
property p_timing_only;
    timing_reg_wr && !cs_mode_reg_wr && !reload_pending ##1 $stable(slow_clock_mode)
        |-> !reload_pending;
endproperty
a_timing_only: assert property (p_timing_only) else $error("timing write armed reload");
// the count may drop to zero at once when an optimized access absorbs it
property p_float_dec;
    float_left != 4'h0 && !busy
        |=> (float_left == $past(float_left) - 4'h1) || (float_left == 4'h0);
endproperty
a_float_dec: assert property (p_float_dec) else $error("float count stuck");
endmodule // smw_ctrl_assertions
`default_nettype wire

// ---- testbench/smw_mem_model.sv ----
// external memory model that answers strobes with a wait pulse
`timescale 1ns/1ps
`default_nettype none
module smw_mem_model (
    // clock
    input wire logic mclk,
    // controller pins
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic [7:0] wait_cycles,
    output logic ext_wait_n
);
logic act_r = 1'b0;
logic [7:0] cnt_r = 8'h00;
// wait is raised one cycle after the strobe falls, inside the pulse only
always @(posedge mclk) begin
    act_r <= !(read_strobe_n && write_strobe_n);
    if (!act_r && !(read_strobe_n && write_strobe_n)) cnt_r <= wait_cycles;
    else if (cnt_r != 8'h00) cnt_r <= cnt_r - 8'h01;
end
// released line falls back to its pull-up level
assign ext_wait_n = (cnt_r == 8'h00);
endmodule // smw_mem_model
`default_nettype wire

// ---- testbench/tb_top.sv ----
// self-checking bench for the wait-state sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
logic mclk, rst_n, cs_mode_reg_wr, timing_reg_wr, slow_clock_mode, req_valid, req_ready;
logic req_internal, req_write, ext_wait_n, read_strobe_n, write_strobe_n, busy, reload_pending;
logic float_hit = 1'b0;
logic [2:0] cfg_cs, req_cs;
logic [7:0] cfg_mode_data, chip_select_n, wait_cyc;
logic [8:0] req_setup, req_pulse, req_hold;
logic [3:0] float_left;
int n_mismatch = 0, checks = 0, cyc = 0, width = 0, last_w = 0, lat = 0, l0 = 0, l1 = 0;
smw_ctrl dut_u (.mclk(mclk), .rst_n(rst_n), .cs_mode_reg_wr(cs_mode_reg_wr), .cfg_cs(cfg_cs),
    .cfg_mode_data(cfg_mode_data), .timing_reg_wr(timing_reg_wr),
    .slow_clock_mode(slow_clock_mode), .req_valid(req_valid), .req_ready(req_ready),
    .req_internal(req_internal), .req_write(req_write), .req_cs(req_cs), .req_setup(req_setup),
    .req_pulse(req_pulse), .req_hold(req_hold), .ext_wait_n(ext_wait_n),
    .chip_select_n(chip_select_n), .read_strobe_n(read_strobe_n),
    .write_strobe_n(write_strobe_n), .busy(busy), .reload_pending(reload_pending),
    .float_left(float_left));
smw_mem_model mem_u (.mclk(mclk), .read_strobe_n(read_strobe_n),
    .write_strobe_n(write_strobe_n), .wait_cycles(wait_cyc), .ext_wait_n(ext_wait_n));
////////////////////////////////////////////////////////////////////////////////
// clock, strobe width monitor and hang limit
initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
end
always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (!read_strobe_n || !write_strobe_n) width <= width + 1;
    else if (width != 0) begin
        last_w <= width;
        width <= 0;
    end
    if (!write_strobe_n && float_left != 4'h0) float_hit <= 1'b1;
    if (cyc == 20000) begin
        n_mismatch++;
        report_and_stop();
    end
end
task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
        n_mismatch++;
        $display("mismatch at %0t: saw %0h want %0h", $time, seen, exp);
    end
endtask
task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
endtask
// one mode word write; fields {tdf_mode, read_mode, wait mode, float count}
task automatic cfg(input logic [2:0] cs, input logic [7:0] d);
    @(posedge mclk) #1;
    cfg_cs = cs;
    cfg_mode_data = d;
    cs_mode_reg_wr = 1'b1;
    @(posedge mclk) #1;
    cs_mode_reg_wr = 1'b0;
endtask
// select is set a cycle early since the mode word is read through a register
task automatic acc(input logic in, input logic wr, input logic [2:0] cs, input logic [8:0] p,
    input logic [7:0] w);
    @(posedge mclk) #1;
    {req_internal, req_write, req_cs, req_pulse, wait_cyc} = {in, wr, cs, p, w};
    lat = 0;
    @(posedge mclk) #1;
    req_valid = 1'b1;
    @(negedge mclk);
    while (req_ready !== 1'b1 && lat < 400) begin
        @(negedge mclk);
        lat++;
    end
    if (lat >= 400) n_mismatch++;
    @(posedge mclk) #1;
    req_valid = 1'b0;
    // step past the edge so that callers never sample a launching edge
    repeat (2) @(posedge mclk);
    #1;
endtask
////////////////////////////////////////////////////////////////////////////////
// main sequence
initial begin
    {rst_n, cs_mode_reg_wr, timing_reg_wr, slow_clock_mode, req_valid, req_internal} = 6'h00;
    {req_write, cfg_cs, req_cs, cfg_mode_data, wait_cyc} = 23'h000000;
    {req_setup, req_pulse, req_hold} = {9'h001, 9'h004, 9'h001};
    repeat (2) @(posedge mclk);
    #1 rst_n = 1'b1;
    chk({chip_select_n, read_strobe_n, write_strobe_n, busy, reload_pending, float_left},
        16'hFFC0);
    timing_reg_wr = 1'b1;
    @(posedge mclk) #1 timing_reg_wr = 1'b0;
    @(posedge mclk) #1 chk(reload_pending, 1'b0);
    cfg(3'h1, 8'h4F);
    @(posedge mclk) #1 chk(reload_pending, 1'b1);
    cfg(3'h2, 8'h60);
    cfg(3'h3, 8'h70);
    cfg(3'h4, 8'h40);
    acc(1'b0, 1'b0, 3'h1, 9'h004, 8'h02);
    chk(last_w, 16'h0004);
    chk(reload_pending, 1'b0);
    chk(float_left != 4'h0, 1'b1);
    acc(1'b1, 1'b0, 3'h0, 9'h004, 8'h00);
    chk(lat, 16'h0000);
    acc(1'b0, 1'b1, 3'h1, 9'h004, 8'h00);
    chk(float_hit, 1'b0);
    acc(1'b0, 1'b0, 3'h2, 9'h005, 8'h03);
    chk(last_w, 16'h0008);
    acc(1'b0, 1'b0, 3'h3, 9'h005, 8'h01);
    chk(last_w, 16'h0005);
    acc(1'b0, 1'b0, 3'h3, 9'h005, 8'h08);
    chk(last_w >= 8, 1'b1);
    acc(1'b0, 1'b0, 3'h4, 9'h004, 8'h00);
    acc(1'b0, 1'b0, 3'h4, 9'h004, 8'h00);
    l0 = lat;
    cfg(3'h2, 8'h60);
    acc(1'b0, 1'b0, 3'h4, 9'h004, 8'h00);
    chk(lat, l0 + 1);
    acc(1'b0, 1'b0, 3'h5, 9'h004, 8'h00);
    l1 = lat;
    acc(1'b0, 1'b0, 3'h4, 9'h004, 8'h00);
    cfg(3'h2, 8'h60);
    acc(1'b0, 1'b0, 3'h5, 9'h004, 8'h00);
    chk(lat, l1);
    slow_clock_mode = 1'b1;
    repeat (2) @(posedge mclk);
    #1 chk(reload_pending, 1'b1);
    acc(1'b0, 1'b0, 3'h4, 9'h004, 8'h00);
    chk(reload_pending, 1'b0);
    // select-controlled read with float optimization on chip select 6
    cfg(3'h6, 8'h8F);
    acc(1'b0, 1'b0, 3'h6, 9'h004, 8'h00);
    chk(float_left, 16'h000D);
    req_setup = 9'h00C;
    acc(1'b0, 1'b1, 3'h6, 9'h004, 8'h00);
    chk(lat, 16'h0012);
    req_setup = 9'h001;
    report_and_stop();
end
endmodule // tb_top
bind smw_ctrl smw_ctrl_assertions #(.CHIP_SELECT_N(CHIP_SELECT_N), .CSW(CSW)) chk_u (.mclk(mclk), .rst_n(rst_n),
    .cs_mode_reg_wr(cs_mode_reg_wr), .timing_reg_wr(timing_reg_wr),
    .slow_clock_mode(slow_clock_mode), .req_valid(req_valid), .req_ready(req_ready),
    .req_internal(req_internal), .chip_select_n(chip_select_n), .read_strobe_n(read_strobe_n),
    .write_strobe_n(write_strobe_n), .busy(busy), .reload_pending(reload_pending),
    .float_left(float_left));
`default_nettype wire
